// File: core/scpm_pkg.sv
// Purpose: shared constants and types of the system clock and power mode block
// Assumes: 8-bit registers, each in the low byte of one 32-bit wishbone word
// Notes: state of the core is one packed struct declared here

package scpm_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_SYS_CLK_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FAST_OSC_CTRL = 8'h04;

    // system_clock_control fields
    localparam int SCC_SEL_LSB = 5;
    localparam int SCC_SEL_MSB = 7;
    localparam int SCC_FAST_KEEP_BIT = 1;
    localparam int SCC_SLOW_KEEP_BIT = 0;

    // fast_oscillator_control fields
    localparam int FOC_STABLE_BIT = 1;
    localparam int FOC_ENABLE_BIT = 0;

    // reset values
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic FAST_KEEP_RST = 1'b0;
    localparam logic SLOW_KEEP_RST = 1'b0;
    localparam logic FAST_EN_RST = 1'b1;

    // select code of the sub clock
    localparam logic [2:0] SEL_SUB = 3'h7;

    // default oscillator settling counts, in oscillator rising edges
    localparam logic [9:0] FAST_STABLE_EDGES_DEF = 10'h100;
    localparam logic [9:0] SLOW_STABLE_EDGES_DEF = 10'h008;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_IDLE_SUB_ONLY,
        MODE_IDLE_BOTH_CLOCKS,
        MODE_IDLE_FAST_ONLY,
        MODE_WAKING
    } scpm_mode_e;

    typedef enum logic [1:0] {
        REG_SYS_CLK_CTRL,
        REG_FAST_OSC_CTRL,
        REG_NONE
    } scpm_reg_e;

    typedef struct packed {
        scpm_mode_e mode;
        logic [2:0] sel;
        logic fast_keep;
        logic slow_keep;
        logic fast_en;
        logic fast_stable;
        logic slow_stable;
        logic [9:0] fast_cnt;
        logic [9:0] slow_cnt;
        logic [1:0] fast_sync;
        logic [1:0] slow_sync;
        logic fast_prev;
        logic slow_prev;
        logic [5:0] div;
        logic [2:0] act_sel;
        logic sys_gate;
        logic sysclk;
        logic fast_clk;
        logic sub_clk;
        logic slow_clk;
        logic fast_run;
        logic cpu_run;
        logic pdf_set;
        logic to_clr;
        logic ack;
        logic [7:0] rdata;
    } scpm_state_s;

endpackage

// File: core/scpm_core.sv
// Purpose: system clock selection, divider and power-down mode control
// Assumes: oscillator outputs arrive as asynchronous levels far slower than sys_clk_i
// Notes: all clocks leave as registered levels; halt and wake come from cpu logic
//
// Implementation choices: the register addresses and the Wishbone register port.

`timescale 1ns/100ps

// Contract
// - select codes 0 to 6 give the fast clock divided by 1 to 64 and code 7 the sub clock.
// - writing the select field alone moves between fast and slow running with the cpu on.
// - halt with both keep bits low enters sleep, stopping cpu, system, fast and sub clocks.
// - halt with fast keep low and slow keep high enters idle_sub_only, system on only for 7.
// - halt with both keep bits high enters idle_both_clocks with every clock still running.
// - halt with fast keep high and slow keep low enters idle_fast_only, system on for 0 to 6.
// - the slow oscillator clock runs in every mode so the watchdog keeps counting.
// - in slow running the fast oscillator runs or stops by its enable bit and feeds peripherals.
// - the fast keep bit decides whether the fast oscillator runs while halted.
// - the slow keep bit decides whether the sub clock reaches peripherals while halted.
// - outside halt the fast oscillator enable starts it at 1, stops it at 0 only in slow running, and resets to 1.
// - setting the enable clears the stable flag, which rises once the oscillator settles.
// - unused bits 4 to 2 and 7 to 2 of the two control registers read as zero.
// - switching the system clock to the sub clock completes only once the slow oscillator is stable.
// - entering any halt mode sets the power-down flag and clears the watchdog time-out flag.
module scpm_core
    import scpm_pkg::*;
#(
    parameter logic [9:0] FAST_STABLE_EDGES = FAST_STABLE_EDGES_DEF,
    parameter logic [9:0] SLOW_STABLE_EDGES = SLOW_STABLE_EDGES_DEF
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // oscillators
    input wire logic fast_osc_clk_i,
    input wire logic slow_osc_clk_i,
    output logic fast_osc_enable_o,
    // cpu side
    input wire logic halt_i,
    input wire logic wake_i,
    output logic cpu_run_o,
    output logic power_down_flag_set_o,
    output logic watchdog_timeout_flag_clr_o,
    // clocks out
    output logic sysclk_o,
    output logic fast_clock_o,
    output logic sub_clock_o,
    output logic slow_osc_clock_o,
    output logic [2:0] mode_o
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic src_level(input logic [2:0] sel, input logic fast_lvl,
                                       input logic [5:0] div, input logic slow_lvl);
        unique case (sel)
            3'h0: src_level = fast_lvl;
            3'h1: src_level = div[0];
            3'h2: src_level = div[1];
            3'h3: src_level = div[2];
            3'h4: src_level = div[3];
            3'h5: src_level = div[4];
            3'h6: src_level = div[5];
            3'h7: src_level = slow_lvl;
        endcase
    endfunction

    function automatic scpm_reg_e reg_index(input logic [7:0] adr);
        if (adr == ADDR_SYS_CLK_CTRL) begin
            reg_index = REG_SYS_CLK_CTRL;
        end else if (adr == ADDR_FAST_OSC_CTRL) begin
            reg_index = REG_FAST_OSC_CTRL;
        end else begin
            reg_index = REG_NONE;
        end
    endfunction

    localparam scpm_state_s RST_STATE = '{
        mode: MODE_RUN, sel: SEL_RST, fast_keep: FAST_KEEP_RST,
        slow_keep: SLOW_KEEP_RST, fast_en: FAST_EN_RST, fast_stable: 1'b0,
        slow_stable: 1'b0, fast_cnt: 10'h000, slow_cnt: 10'h000,
        fast_sync: 2'h0, slow_sync: 2'h0, fast_prev: 1'b0, slow_prev: 1'b0,
        div: 6'h00, act_sel: SEL_RST, sys_gate: 1'b1, sysclk: 1'b0,
        fast_clk: 1'b0, sub_clk: 1'b0, slow_clk: 1'b0, fast_run: 1'b1,
        cpu_run: 1'b1, pdf_set: 1'b0, to_clr: 1'b0, ack: 1'b0, rdata: 8'h00
    };

    scpm_state_s s;
    scpm_state_s next_s;
    logic fast_lvl;
    logic slow_lvl;
    logic cur_lvl;
    logic new_lvl;
    logic active;
    logic want_sys;
    logic new_src_ok;
    logic wr_take;
    logic fast_en_rise;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.pdf_set = 1'b0;
        next_s.to_clr = 1'b0;

        // first stage is read only by the second
        next_s.fast_sync = {s.fast_sync[0], fast_osc_clk_i};
        next_s.slow_sync = {s.slow_sync[0], slow_osc_clk_i};
        fast_lvl = s.fast_sync[1];
        slow_lvl = s.slow_sync[1];
        next_s.fast_prev = fast_lvl;
        next_s.slow_prev = slow_lvl;

        // divider chain counts fast oscillator edges
        if (fast_lvl && !s.fast_prev) begin
            next_s.div = s.div + 6'h01;
        end

        active = (s.mode == MODE_RUN) || (s.mode == MODE_WAKING);

        // fast oscillator keeps running while it still feeds the system clock
        if (active) begin
            next_s.fast_run = s.fast_en || (s.sel != SEL_SUB) || (s.act_sel != SEL_SUB);
        end else begin
            next_s.fast_run = s.fast_keep;
        end

        // settling counters
        if (!s.fast_run) begin
            next_s.fast_cnt = 10'h000;
            next_s.fast_stable = 1'b0;
        end else if (fast_lvl && !s.fast_prev && !s.fast_stable) begin
            next_s.fast_cnt = s.fast_cnt + 10'h001;
            next_s.fast_stable = (s.fast_cnt == FAST_STABLE_EDGES - 10'h001);
        end
        if (slow_lvl && !s.slow_prev && !s.slow_stable) begin
            next_s.slow_cnt = s.slow_cnt + 10'h001;
            next_s.slow_stable = (s.slow_cnt == SLOW_STABLE_EDGES - 10'h001);
        end

        // source switch only while both old and new levels are low, so neither
        // phase is ever cut short; the new source must have settled first
        cur_lvl = src_level(s.act_sel, fast_lvl, s.div, slow_lvl);
        new_lvl = src_level(s.sel, fast_lvl, s.div, slow_lvl);
        new_src_ok = (s.sel == SEL_SUB) ? s.slow_stable : s.fast_stable;
        if ((s.sel != s.act_sel) && !cur_lvl && !new_lvl && new_src_ok) begin
            next_s.act_sel = s.sel;
        end

        unique case (s.mode)
            MODE_RUN: want_sys = 1'b1;
            MODE_WAKING: want_sys = 1'b1;
            MODE_SLEEP: want_sys = 1'b0;
            MODE_IDLE_SUB_ONLY: want_sys = (s.act_sel == SEL_SUB);
            MODE_IDLE_BOTH_CLOCKS: want_sys = 1'b1;
            MODE_IDLE_FAST_ONLY: want_sys = (s.act_sel != SEL_SUB);
            default: want_sys = 1'b0;
        endcase
        // gate moves only in a low phase of the system clock
        if (!cur_lvl) begin
            next_s.sys_gate = want_sys;
        end

        next_s.sysclk = cur_lvl && s.sys_gate;
        next_s.fast_clk = fast_lvl && s.fast_run && s.fast_stable;
        next_s.sub_clk = slow_lvl && (active || s.slow_keep);
        next_s.slow_clk = slow_lvl;

        // operating mode
        unique case (s.mode)
            MODE_RUN: begin
                if (halt_i) begin
                    next_s.pdf_set = 1'b1;
                    next_s.to_clr = 1'b1;
                    unique case ({s.fast_keep, s.slow_keep})
                        2'b00: next_s.mode = MODE_SLEEP;
                        2'b01: next_s.mode = MODE_IDLE_SUB_ONLY;
                        2'b11: next_s.mode = MODE_IDLE_BOTH_CLOCKS;
                        2'b10: next_s.mode = MODE_IDLE_FAST_ONLY;
                    endcase
                end
            end
            MODE_SLEEP, MODE_IDLE_SUB_ONLY, MODE_IDLE_BOTH_CLOCKS, MODE_IDLE_FAST_ONLY: begin
                if (wake_i) begin
                    next_s.mode = MODE_WAKING;
                end
            end
            MODE_WAKING: begin
                // cpu waits for the selected source and an open gate
                if (new_src_ok && (s.act_sel == s.sel) && s.sys_gate) begin
                    next_s.mode = MODE_RUN;
                end
            end
            default: next_s.mode = MODE_RUN;
        endcase
        next_s.cpu_run = (next_s.mode == MODE_RUN);

        // wishbone: ack one cycle after the request, write at the acked edge
        next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
        if (next_s.ack) begin
            unique case (reg_index(wb_adr_i))
                REG_SYS_CLK_CTRL: next_s.rdata = {s.sel, 3'h0, s.fast_keep, s.slow_keep};
                REG_FAST_OSC_CTRL: next_s.rdata = {6'h00, s.fast_stable, s.fast_en};
                default: next_s.rdata = 8'h00;
            endcase
        end
        wr_take = wb_cyc_i && wb_stb_i && s.ack && wb_we_i && wb_sel_i[0];
        fast_en_rise = 1'b0;
        if (wr_take) begin
            unique case (reg_index(wb_adr_i))
                REG_SYS_CLK_CTRL: begin
                    next_s.sel = wb_dat_i[SCC_SEL_MSB:SCC_SEL_LSB];
                    next_s.fast_keep = wb_dat_i[SCC_FAST_KEEP_BIT];
                    next_s.slow_keep = wb_dat_i[SCC_SLOW_KEEP_BIT];
                end
                REG_FAST_OSC_CTRL: begin
                    next_s.fast_en = wb_dat_i[FOC_ENABLE_BIT];
                    if (wb_dat_i[FOC_ENABLE_BIT] && !s.fast_en) begin
                        fast_en_rise = 1'b1;
                        next_s.fast_cnt = 10'h000;
                        next_s.fast_stable = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign wb_dat_o = {24'h000000, s.rdata};
    assign wb_ack_o = s.ack;
    assign fast_osc_enable_o = s.fast_run;
    assign cpu_run_o = s.cpu_run;
    assign power_down_flag_set_o = s.pdf_set;
    assign watchdog_timeout_flag_clr_o = s.to_clr;
    assign sysclk_o = s.sysclk;
    assign fast_clock_o = s.fast_clk;
    assign sub_clock_o = s.sub_clk;
    assign slow_osc_clock_o = s.slow_clk;
    assign mode_o = s.mode;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_sub_source;
        @(posedge sys_clk_i) disable iff (rst_i)
        (s.act_sel == SEL_SUB && s.sys_gate) |=> (s.sysclk == $past(s.slow_sync[1]));
    endproperty
    a_sub_source: assert property (p_sub_source) else $error("sub clock not on system clock");

    property p_run_stays;
        @(posedge sys_clk_i) disable iff (rst_i)
        (s.mode == MODE_RUN && !halt_i) |=> (s.mode == MODE_RUN && s.cpu_run);
    endproperty
    a_run_stays: assert property (p_run_stays) else $error("run left without halt");

    property p_sleep_off;
        @(posedge sys_clk_i) disable iff (rst_i)
        (s.mode == MODE_SLEEP && $past(s.mode) == MODE_SLEEP)
            |-> (!s.cpu_run && !s.fast_run && !s.sub_clk);
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("clock alive in sleep");

    property p_idle_sub;
        @(posedge sys_clk_i) disable iff (rst_i)
        (s.mode == MODE_RUN && halt_i && !s.fast_keep && s.slow_keep)
            |=> (s.mode == MODE_IDLE_SUB_ONLY) ##1 !s.fast_run;
    endproperty
    a_idle_sub: assert property (p_idle_sub) else $error("idle_sub_only entry wrong");

    property p_idle_both;
        @(posedge sys_clk_i) disable iff (rst_i)
        (s.mode == MODE_RUN && halt_i && s.fast_keep && s.slow_keep)
            |=> (s.mode == MODE_IDLE_BOTH_CLOCKS && !s.cpu_run) ##1 s.fast_run;
    endproperty
    a_idle_both: assert property (p_idle_both) else $error("idle_both_clocks entry wrong");

    property p_idle_fast;
        @(posedge sys_clk_i) disable iff (rst_i)
        (s.mode == MODE_RUN && halt_i && s.fast_keep && !s.slow_keep)
            |=> (s.mode == MODE_IDLE_FAST_ONLY) ##1 (s.fast_run && !s.sub_clk);
    endproperty
    a_idle_fast: assert property (p_idle_fast) else $error("idle_fast_only entry wrong");

    property p_slow_always;
        @(posedge sys_clk_i) disable iff (rst_i)
        1'b1 |=> (s.slow_clk == $past(s.slow_sync[1]));
    endproperty
    a_slow_always: assert property (p_slow_always) else $error("slow oscillator clock gated");

    property p_stable_clear;
        @(posedge sys_clk_i) disable iff (rst_i)
        fast_en_rise |=> (!s.fast_stable && s.fast_en);
    endproperty
    a_stable_clear: assert property (p_stable_clear) else $error("stable flag not cleared");

    property p_reserved_zero;
        @(posedge sys_clk_i) disable iff (rst_i)
        (next_s.ack && reg_index(wb_adr_i) == REG_FAST_OSC_CTRL) |=> (s.rdata[7:2] == 6'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

    property p_sub_needs_stable;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(s.act_sel == SEL_SUB) |-> $past(s.slow_stable);
    endproperty
    a_sub_needs_stable: assert property (p_sub_needs_stable) else $error("unstable sub switch");

    property p_halt_flags;
        @(posedge sys_clk_i) disable iff (rst_i)
        (s.mode == MODE_RUN && halt_i) |=> (s.pdf_set && s.to_clr) ##1 (!s.pdf_set && !s.to_clr);
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("halt flag pulses wrong");

    property p_wake_restore;
        @(posedge sys_clk_i) disable iff (rst_i)
        (s.mode == MODE_WAKING ##1 s.mode == MODE_RUN) |-> $past(s.act_sel == s.sel && s.sys_gate);
    endproperty
    a_wake_restore: assert property (p_wake_restore) else $error("cpu resumed early");

    // a source or gate move launched in a high phase would cut that phase short
    property p_switch_low;
        @(posedge sys_clk_i) disable iff (rst_i)
        ($changed(s.act_sel) || $changed(s.sys_gate)) |-> !s.sysclk;
    endproperty
    a_switch_low: assert property (p_switch_low) else $error("clock switched in high phase");

endmodule

// File: verif/scpm_osc_model.sv
// Purpose: behavioural model of the fast and slow rc oscillators beside the clock block
// Assumes: both oscillators run far slower than the 200 MHz system clock
// Notes: phases are unrelated to the system clock so the synchronisers see real skew

`timescale 1ns/100ps

module scpm_osc_model #(
    parameter int FAST_HALF_NS = 20,
    parameter int SLOW_HALF_NS = 200
) (
    // run request from the block
    input wire logic enable_i,
    // oscillator outputs
    output logic fast_osc_clk_o,
    output logic slow_osc_clk_o
);
    // ------------------------------------------------------------------
    // fast oscillator
    // ------------------------------------------------------------------
    // a stopped oscillator parks low instead of freezing at its last level
    initial begin
        fast_osc_clk_o = 1'b0;
        forever begin
            #(FAST_HALF_NS);
            fast_osc_clk_o = enable_i ? ~fast_osc_clk_o : 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // slow oscillator
    // ------------------------------------------------------------------
    // free running: nothing in the block may stop it
    initial begin
        slow_osc_clk_o = 1'b0;
        #3;
        forever begin
            #(SLOW_HALF_NS);
            slow_osc_clk_o = ~slow_osc_clk_o;
        end
    end
endmodule

// File: verif/sys_clock_power_modes_bench.sv
// Purpose: self-checking bench of the clock select and power-down mode block
// Assumes: settle counts shortened to 4 fast and 2 slow edges
// Notes: clocks are judged by counting rising edges over fixed windows

`timescale 1ns/100ps

module sys_clock_power_modes_bench;
    import scpm_pkg::*;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic halt = 1'b0;
    logic wake = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, fast_osc, slow_osc, fast_osc_enable_o, cpu_run_o;
    logic power_down_flag_set_o, watchdog_timeout_flag_clr_o;
    logic sysclk_o, fast_clock_o, sub_clock_o, slow_osc_clock_o;
    logic [2:0] mode_o;
    int err_total = 0;
    int tests_run = 0;
    int seed = 32'hecc7cee3;
    int cnt[4];
    logic [7:0] rd;
    logic [2:0] sel;
    scpm_mode_e em[4] = '{MODE_SLEEP, MODE_IDLE_SUB_ONLY, MODE_IDLE_FAST_ONLY,
                          MODE_IDLE_BOTH_CLOCKS};

    always #2.5 sys_clk = ~sys_clk;

    scpm_core #(.FAST_STABLE_EDGES(10'h004), .SLOW_STABLE_EDGES(10'h002)) u_scpm_core (
        .sys_clk_i(sys_clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fast_osc_clk_i(fast_osc),
        .slow_osc_clk_i(slow_osc), .fast_osc_enable_o(fast_osc_enable_o),
        .halt_i(halt), .wake_i(wake), .cpu_run_o(cpu_run_o),
        .power_down_flag_set_o(power_down_flag_set_o),
        .watchdog_timeout_flag_clr_o(watchdog_timeout_flag_clr_o),
        .sysclk_o(sysclk_o), .fast_clock_o(fast_clock_o), .sub_clock_o(sub_clock_o),
        .slow_osc_clock_o(slow_osc_clock_o), .mode_o(mode_o));

    scpm_osc_model u_scpm_osc_model (.enable_i(fast_osc_enable_o),
        .fast_osc_clk_o(fast_osc), .slow_osc_clk_o(slow_osc));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic end_sim();
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // classic single cycle; the master never assumes the ack latency
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] be,
                           input logic [7:0] wd, output logic [7:0] rdat);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= be;
        wb_dat <= {24'h0, wd};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rdat = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 50) begin
            chk("bus ack", 1, 0);
            end_sim();
        end
    endtask

    // rising edges of sysclk, fast, sub and slow outputs, in that order
    task automatic count_edges(input int n);
        logic [3:0] prev;
        logic [3:0] cur;
        prev = {sysclk_o, fast_clock_o, sub_clock_o, slow_osc_clock_o};
        cnt = '{default: 0};
        repeat (n) begin
            @(posedge sys_clk);
            cur = {sysclk_o, fast_clock_o, sub_clock_o, slow_osc_clock_o};
            for (int i = 0; i < 4; i++) begin
                if (cur[3 - i] && !prev[3 - i]) cnt[i]++;
            end
            prev = cur;
        end
    endtask

    function automatic logic near(input int a, input int b);
        return (a - b <= 1) && (b - a <= 1);
    endfunction

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        int n;
        logic [2:0] junk;
        cyc_wait(4);
        rst <= 1'b0;
        cyc_wait(2);
        chk("enable reset", 1, fast_osc_enable_o);
        chk("mode reset", 3'(MODE_RUN), mode_o);
        wb_xfer(1'b0, ADDR_SYS_CLK_CTRL, 4'hf, 8'h00, rd);
        chk("scc reset", 8'h00, rd);
        wb_xfer(1'b0, ADDR_FAST_OSC_CTRL, 4'hf, 8'h00, rd);
        chk("foc enable reset", 1, rd[FOC_ENABLE_BIT]);
        // unused bits, unmapped places and a write with byte lane 0 off
        junk = 3'($unsigned($random(seed)));
        wb_xfer(1'b1, ADDR_SYS_CLK_CTRL, 4'hf, {3'h5, junk | 3'h1, 2'h2}, rd);
        wb_xfer(1'b1, ADDR_SYS_CLK_CTRL, 4'he, 8'hff, rd);
        wb_xfer(1'b1, 8'h0c, 4'hf, 8'hff, rd);
        wb_xfer(1'b0, ADDR_SYS_CLK_CTRL, 4'hf, 8'h00, rd);
        chk("scc readback", 8'ha2, rd);
        wb_xfer(1'b1, ADDR_FAST_OSC_CTRL, 4'hf, 8'hff, rd);
        cyc_wait(100);
        wb_xfer(1'b0, ADDR_FAST_OSC_CTRL, 4'hf, 8'h00, rd);
        chk("foc readback", 8'h03, rd);
        wb_xfer(1'b0, 8'h08, 4'hf, 8'h00, rd);
        chk("unmapped read", 8'h00, rd);
        // every select code with the cpu left running
        for (int s = 0; s < 8; s++) begin
            wb_xfer(1'b1, ADDR_SYS_CLK_CTRL, 4'h1, {3'(s), 5'h00}, rd);
            // the switch waits for both divided levels low, which can take one period of the slowest division
            cyc_wait(700);
            count_edges(2000);
            n = (s == 7) ? cnt[3] : cnt[1] >> s;
            chk("sysclk rate", 1, near(cnt[0], n));
            chk("cpu running", 1, cpu_run_o);
        end
        // slow running: fast oscillator follows its enable
        wb_xfer(1'b1, ADDR_FAST_OSC_CTRL, 4'h1, 8'h00, rd);
        cyc_wait(50);
        chk("osc stopped", 0, fast_osc_enable_o);
        count_edges(200);
        chk("fast clock off", 0, cnt[1]);
        wb_xfer(1'b1, ADDR_FAST_OSC_CTRL, 4'h1, 8'h01, rd);
        wb_xfer(1'b0, ADDR_FAST_OSC_CTRL, 4'hf, 8'h00, rd);
        chk("stable cleared", 8'h01, rd);
        n = 0;
        while (rd[FOC_STABLE_BIT] !== 1'b1 && n < 100) begin
            wb_xfer(1'b0, ADDR_FAST_OSC_CTRL, 4'hf, 8'h00, rd);
            n++;
        end
        if (n >= 100) begin
            chk("stable timeout", 1, 0);
            end_sim();
        end
        chk("stable set", 1, rd[FOC_STABLE_BIT]);
        count_edges(200);
        chk("fast clock on", 1, cnt[1] > 0);
        // every halt mode, with a fast and with the sub clock selected
        for (int k = 0; k < 4; k++) begin
            for (int s = 0; s < 2; s++) begin
                sel = s ? SEL_SUB : 3'($unsigned($random(seed)) % 7);
                wb_xfer(1'b1, ADDR_SYS_CLK_CTRL, 4'h1, {sel, 3'h0, 2'(k)}, rd);
                cyc_wait(700);
                halt <= 1'b1;
                @(posedge sys_clk);
                halt <= 1'b0;
                @(posedge sys_clk);
                chk("halt mode", 3'(em[k]), mode_o);
                chk("cpu stopped", 0, cpu_run_o);
                chk("pdf pulse", 1, power_down_flag_set_o);
                chk("to pulse", 1, watchdog_timeout_flag_clr_o);
                cyc_wait(3);
                chk("fast keep", k[1], fast_osc_enable_o);
                count_edges(600);
                chk("sys gate", k == 3 || (k == 1 && s == 1) || (k == 2 && s == 0),
                    cnt[0] > 0);
                chk("fast gate", k[1], cnt[1] > 0);
                chk("sub gate", k[0], cnt[2] > 0);
                chk("slow runs", 1, cnt[3] > 0);
                wake <= 1'b1;
                @(posedge sys_clk);
                wake <= 1'b0;
                n = 0;
                while (cpu_run_o !== 1'b1 && n < 3000) begin
                    @(posedge sys_clk);
                    n++;
                end
                if (n >= 3000) begin
                    chk("wake timeout", 1, 0);
                    end_sim();
                end
                chk("woken", 3'(MODE_RUN), mode_o);
                // window longer than one period of the slowest division
                count_edges(600);
                chk("sysclk back", 1, cnt[0] > 0);
            end
        end
        end_sim();
    end
endmodule
